// ---- rtl/tli_params.svh ----
// offsets, field positions, reset values and timing counts of the lut control registers
// assumes inclusion by bare name from the design file
`ifndef TLI_PARAMS_SVH
`define TLI_PARAMS_SVH

`define TLI_OFS_INDEX      8'h81
`define TLI_OFS_MOD_HI     8'h82
`define TLI_OFS_MOD_LO     8'h83
`define TLI_OFS_AUX1_HI    8'h84
`define TLI_OFS_AUX1_LO    8'h85
`define TLI_OFS_AUX2_HI    8'h86
`define TLI_OFS_AUX2_LO    8'h87
`define TLI_OFS_PERIOD     8'h88

`define TLI_RST_INDEX      8'h00
`define TLI_RST_CODE       9'h000
`define TLI_RST_PERIOD     8'h00

`define TLI_INDEX_BASE     8'h80
`define TLI_INDEX_MAX      8'hC7
`define TLI_TEMP_MIN       16'shD800
`define TLI_TEMP_MAX       16'sh6600
`define TLI_TEMP_OFS       17'sh0_2800
`define TLI_TEMP_SHIFT     9

`define TLI_PERIOD_SEL_MSB 2
`define TLI_CODE_MSB       8

`define TLI_CLK_NS         25
`define TLI_T0_NS          800
`define TLI_T1_NS          1200
`define TLI_T2_NS          1600
`define TLI_T3_NS          2000
`define TLI_T4_NS          2800
`define TLI_T5_NS          3200
`define TLI_T6_NS          4400
`define TLI_T7_NS          6400
`define TLI_NS2CYC(t)      (((t) + `TLI_CLK_NS - 1) / `TLI_CLK_NS)

`endif

// ---- rtl/tli_pkg.sv ----
// types shared by the lut control register bank
// assumes tli_params.svh on the include path
package tli_pkg;

  typedef struct packed {
    logic top_password_level;
    logic lower_password_level;
    logic table_readwrite_permit;
    logic table_readonly_permit;
  } tli_access_type;

  typedef struct packed {
    logic auto_index_enable;
    logic auto_mod_enable;
    logic auto_aux1_enable;
    logic auto_aux2_enable;
  } tli_auto_type;

  typedef struct packed {
    logic [8:0] mod_code;
    logic [8:0] apc_code;
    logic [8:0] aux1_code;
    logic [8:0] aux2_code;
  } tli_codes_type;

  typedef struct packed {
    logic [7:0] mod_addr;
    logic [7:0] shared_addr;
  } tli_lut_addr_type;

endpackage : tli_pkg

// ---- rtl/tli_regs.sv ----
// temperature-indexed lut control registers: index, value codes and loop sample period
// assumes a serial-bus front end giving byte strobes and a stop pulse, and
// combinational lut data for the addresses presented
`timescale 1ns/1ps
`include "tli_params.svh"

// How it works
// [RULE1] index equals (temperature plus 40 C) over 2 C, plus 80h, held in register
// [RULE2] index clamps to 80h below -40 C and to C7h above +102 C
// [RULE3] index written only with auto indexing off and write permission
// [RULE4] modulation table address is 1 then index bits 6 to 0
// [RULE5] reference and auxiliary tables use 1, 0, then index bits 6 to 1
// [RULE6] modulation code recalled into its register each conversion end; upper bits zero
// [RULE7] modulation register written only with auto modulation off and write permission
// [RULE8] first auxiliary code recalled into its register at each conversion end
// [RULE9] first auxiliary register written only with its auto off and write permission
// [RULE10] second auxiliary code recalled into its register at each conversion end
// [RULE11] second auxiliary register written only with its auto off and write permission
// [RULE12] period select bits 2 to 0 choose 800 to 6400 ns loop sample period
// [RULE13] reads need top level, or lower level with read-write or read-only permit
// [RULE14] period register writes need write permission; resets to 00h
// [RULE15] manual index shows in value registers after next conversion end only
// [RULE16] manual value reaches its output at the stop that ends the write
// [RULE17] recall skipped for any value register whose auto control is off
module tli_regs
  import tli_pkg::*;
(
  input  wire logic               i_mclk,
  input  wire logic               i_rst_n,
  input  wire logic signed [15:0] i_temp_value,
  input  wire logic               i_conv_done,
  input  wire tli_access_type     i_access,
  input  wire tli_auto_type       i_auto,
  input  wire tli_codes_type      i_lut_data,
  input  wire logic [7:0]         i_reg_addr,
  input  wire logic [7:0]         i_reg_wdata,
  input  wire logic               i_reg_wr,
  input  wire logic               i_reg_rd,
  input  wire logic               i_bus_stop,
  output tli_lut_addr_type        o_lut_addr,
  output logic [7:0]              o_reg_rdata,
  output logic                    o_reg_rd_ok,
  output tli_codes_type           o_out_codes,
  output logic [8:0]              o_sample_cycles,
  output logic                    o_sample_tick
);

  function automatic logic [7:0] tli_calc_index(input logic signed [15:0] t);
    logic signed [16:0] s;
    logic [7:0]         r;
    s = 17'(t) + `TLI_TEMP_OFS;
    if (t < `TLI_TEMP_MIN)
    begin
      r = `TLI_INDEX_BASE;
    end
    else if (t > `TLI_TEMP_MAX)
    begin
      r = `TLI_INDEX_MAX;
    end
    else
    begin
      r = `TLI_INDEX_BASE + 8'(s >>> `TLI_TEMP_SHIFT);
    end
    return r;
  endfunction : tli_calc_index

  function automatic logic [8:0] tli_period_cycles(input logic [2:0] sel);
    logic [8:0] c;
    c = 9'h000;
    unique case (sel)
      3'h0: c = 9'(`TLI_NS2CYC(`TLI_T0_NS));
      3'h1: c = 9'(`TLI_NS2CYC(`TLI_T1_NS));
      3'h2: c = 9'(`TLI_NS2CYC(`TLI_T2_NS));
      3'h3: c = 9'(`TLI_NS2CYC(`TLI_T3_NS));
      3'h4: c = 9'(`TLI_NS2CYC(`TLI_T4_NS));
      3'h5: c = 9'(`TLI_NS2CYC(`TLI_T5_NS));
      3'h6: c = 9'(`TLI_NS2CYC(`TLI_T6_NS));
      3'h7: c = 9'(`TLI_NS2CYC(`TLI_T7_NS));
    endcase
    return c;
  endfunction : tli_period_cycles

  function automatic logic [8:0] tli_byte_merge(input logic [8:0] cur, input logic hi,
                                                input logic [7:0] d);
    return hi ? {d[0], cur[7:0]} : {cur[8], d};
  endfunction : tli_byte_merge

  logic [7:0]    index_r;
  logic [8:0]    mod_r;
  logic [8:0]    aux1_r;
  logic [8:0]    aux2_r;
  logic [7:0]    period_r;
  logic          recall_r;
  logic          pend_mod_r;
  logic          pend_aux1_r;
  logic          pend_aux2_r;
  tli_codes_type out_r;
  logic [7:0]    rdata_r;
  logic          rd_ok_r;
  logic [8:0]    tick_cnt_r;
  logic          tick_r;

  wire logic can_read;
  wire logic can_write;
  wire logic wr_index;
  wire logic wr_mod;
  wire logic wr_aux1;
  wire logic wr_aux2;
  wire logic wr_period;
  wire logic hi_byte;
  wire logic [8:0] period_cyc;
  wire logic tick_wrap;
  logic [7:0] rd_mux;

  // read and write permission from the password state
  assign can_read  = i_access.top_password_level |
                     (i_access.lower_password_level &
                      (i_access.table_readwrite_permit | i_access.table_readonly_permit)); // [RULE13]
  assign can_write = i_access.top_password_level |
                     (i_access.lower_password_level & i_access.table_readwrite_permit);

  assign hi_byte   = ~i_reg_addr[0];
  assign wr_index  = i_reg_wr & can_write & ~i_auto.auto_index_enable &
                     (i_reg_addr == `TLI_OFS_INDEX); // [RULE3]
  assign wr_mod    = i_reg_wr & can_write & ~i_auto.auto_mod_enable &
                     ((i_reg_addr == `TLI_OFS_MOD_HI) | (i_reg_addr == `TLI_OFS_MOD_LO)); // [RULE7]
  assign wr_aux1   = i_reg_wr & can_write & ~i_auto.auto_aux1_enable &
                     ((i_reg_addr == `TLI_OFS_AUX1_HI) | (i_reg_addr == `TLI_OFS_AUX1_LO)); // [RULE9]
  assign wr_aux2   = i_reg_wr & can_write & ~i_auto.auto_aux2_enable &
                     ((i_reg_addr == `TLI_OFS_AUX2_HI) | (i_reg_addr == `TLI_OFS_AUX2_LO)); // [RULE11]
  assign wr_period = i_reg_wr & can_write & (i_reg_addr == `TLI_OFS_PERIOD); // [RULE14]

  // lut addresses from the held index
  assign o_lut_addr.mod_addr    = {1'b1, index_r[6:0]}; // [RULE4]
  assign o_lut_addr.shared_addr = {2'b10, index_r[6:1]}; // [RULE5]

  assign period_cyc = tli_period_cycles(period_r[`TLI_PERIOD_SEL_MSB:0]); // [RULE12]
  assign tick_wrap  = (tick_cnt_r >= period_cyc - 9'h001);

  always_comb
  begin
    rd_mux = 8'h00;
    unique case (i_reg_addr)
      `TLI_OFS_INDEX:   rd_mux = index_r;
      `TLI_OFS_MOD_HI:  rd_mux = {7'h00, mod_r[8]}; // [RULE6]
      `TLI_OFS_MOD_LO:  rd_mux = mod_r[7:0];
      `TLI_OFS_AUX1_HI: rd_mux = {7'h00, aux1_r[8]};
      `TLI_OFS_AUX1_LO: rd_mux = aux1_r[7:0];
      `TLI_OFS_AUX2_HI: rd_mux = {7'h00, aux2_r[8]};
      `TLI_OFS_AUX2_LO: rd_mux = aux2_r[7:0];
      `TLI_OFS_PERIOD:  rd_mux = period_r;
      default:          rd_mux = 8'h00;
    endcase
  end

  // index: computed at conversion end, or host-written while auto indexing is off
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      index_r  <= `TLI_RST_INDEX;
      recall_r <= 1'b0;
    end
    else
    begin
      if (i_conv_done && i_auto.auto_index_enable)
      begin
        index_r <= tli_calc_index(i_temp_value); // [RULE1] [RULE2]
      end
      else if (wr_index)
      begin
        index_r <= i_reg_wdata; // [RULE3]
      end
      recall_r <= i_conv_done; // [RULE15]
    end
  end

  // value registers: recall one cycle after conversion end, using the updated index
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      mod_r  <= `TLI_RST_CODE;
      aux1_r <= `TLI_RST_CODE;
      aux2_r <= `TLI_RST_CODE;
    end
    else
    begin
      if (recall_r && i_auto.auto_mod_enable)
      begin
        mod_r <= i_lut_data.mod_code; // [RULE6] [RULE17]
      end
      else if (wr_mod)
      begin
        mod_r <= tli_byte_merge(mod_r, hi_byte, i_reg_wdata); // [RULE7]
      end
      if (recall_r && i_auto.auto_aux1_enable)
      begin
        aux1_r <= i_lut_data.aux1_code; // [RULE8] [RULE17]
      end
      else if (wr_aux1)
      begin
        aux1_r <= tli_byte_merge(aux1_r, hi_byte, i_reg_wdata); // [RULE9]
      end
      if (recall_r && i_auto.auto_aux2_enable)
      begin
        aux2_r <= i_lut_data.aux2_code; // [RULE10] [RULE17]
      end
      else if (wr_aux2)
      begin
        aux2_r <= tli_byte_merge(aux2_r, hi_byte, i_reg_wdata); // [RULE11]
      end
    end
  end

  // pending manual writes wait for the stop; set wins over the clear
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pend_mod_r  <= 1'b0;
      pend_aux1_r <= 1'b0;
      pend_aux2_r <= 1'b0;
    end
    else
    begin
      pend_mod_r  <= wr_mod  | (pend_mod_r  & ~i_bus_stop);
      pend_aux1_r <= wr_aux1 | (pend_aux1_r & ~i_bus_stop);
      pend_aux2_r <= wr_aux2 | (pend_aux2_r & ~i_bus_stop);
    end
  end

  // outputs follow recall in auto mode and the stop in manual mode
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      out_r <= '0;
    end
    else
    begin
      if (recall_r)
      begin
        out_r.apc_code <= i_lut_data.apc_code;
      end
      if (recall_r && i_auto.auto_mod_enable)
      begin
        out_r.mod_code <= i_lut_data.mod_code;
      end
      else if (i_bus_stop && pend_mod_r)
      begin
        out_r.mod_code <= mod_r; // [RULE16]
      end
      if (recall_r && i_auto.auto_aux1_enable)
      begin
        out_r.aux1_code <= i_lut_data.aux1_code;
      end
      else if (i_bus_stop && pend_aux1_r)
      begin
        out_r.aux1_code <= aux1_r; // [RULE16]
      end
      if (recall_r && i_auto.auto_aux2_enable)
      begin
        out_r.aux2_code <= i_lut_data.aux2_code;
      end
      else if (i_bus_stop && pend_aux2_r)
      begin
        out_r.aux2_code <= aux2_r; // [RULE16]
      end
    end
  end

  // period register and loop sample tick
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      period_r   <= `TLI_RST_PERIOD; // [RULE14]
      tick_cnt_r <= 9'h000;
      tick_r     <= 1'b0;
    end
    else
    begin
      if (wr_period)
      begin
        period_r <= i_reg_wdata; // [RULE14]
      end
      tick_cnt_r <= tick_wrap ? 9'h000 : tick_cnt_r + 9'h001; // [RULE12]
      tick_r     <= tick_wrap;
    end
  end

  // registered read answer; refused or unmapped reads give zero
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rdata_r <= 8'h00;
      rd_ok_r <= 1'b0;
    end
    else
    begin
      rd_ok_r <= i_reg_rd & can_read;
      if (i_reg_rd)
      begin
        rdata_r <= can_read ? rd_mux : 8'h00; // [RULE13]
      end
    end
  end

  assign o_reg_rdata     = rdata_r;
  assign o_reg_rd_ok     = rd_ok_r;
  assign o_out_codes     = out_r;
  assign o_sample_cycles = period_cyc;
  assign o_sample_tick   = tick_r;

endmodule : tli_regs

// ---- test/temp_indexed_lut_ctrl_regs_tb.sv ----
// self-checking bench of the lut control registers
// assumes tli_regs, tli_lut_model and the checker
`timescale 1ns/1ps
module temp_indexed_lut_ctrl_regs_tb;
  import tli_pkg::*;
  logic               clk, rst_n, conv, wr, rd, stp, rok, tick, rd_d;
  logic signed [15:0] temp;
  logic [7:0]         addr, wd, rdat, idx, p;
  logic [8:0]         cyc, v;
  tli_access_type     acc;
  tli_auto_type       aut;
  tli_codes_type      lut, outc, eo;
  tli_lut_addr_type   la;
  logic [8:0]         q[$];
  int                 n_fail, tests_run, n, sh;
  int                 tv[7] = '{-12000, -10240, 26112, 30000, 0, 0, 0};
  int                 ns[8] = '{800, 1200, 1600, 2000, 2800, 3200, 4400, 6400};
  tli_regs dut_u (.i_mclk(clk), .i_rst_n(rst_n), .i_temp_value(temp), .i_conv_done(conv),
    .i_access(acc), .i_auto(aut), .i_lut_data(lut), .i_reg_addr(addr), .i_reg_wdata(wd),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_bus_stop(stp), .o_lut_addr(la), .o_reg_rdata(rdat),
    .o_reg_rd_ok(rok), .o_out_codes(outc), .o_sample_cycles(cyc), .o_sample_tick(tick));
  tli_lut_model lut_u (.i_addr(la), .o_data(lut));
  task chk(input string nm, input logic [35:0] s, input logic [35:0] e);
    tests_run++;
    if (s !== e)
    begin
      n_fail++;
      $display("Error %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task rdx(input logic [7:0] a, input logic [8:0] e);
    @(posedge clk);
    #2 rd = 1;
    addr = a;
    q.push_back(e);
    @(posedge clk);
    #2 rd = 0;
  endtask : rdx
  task wrx(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #2 wr = 1;
    addr = a;
    wd = d;
    @(posedge clk);
    #2 wr = 0;
  endtask : wrx
  task bstop();
    @(posedge clk);
    #2 stp = 1;
    @(posedge clk);
    #2 stp = 0;
  endtask : bstop
  task cv(input int t);
    @(posedge clk);
    #2 temp = 16'(t);
    conv = 1;
    @(posedge clk);
    #2 conv = 0;
    repeat (2) @(posedge clk);
    #2;
  endtask : cv
  function logic [7:0] idx_of(input int t);
    if (t < -10240) return 8'h80;
    if (t > 26112) return 8'hC7;
    return 8'h80 + 8'((t + 10240) >>> 9);
  endfunction : idx_of
  function tli_codes_type lutc(input logic [7:0] i);
    logic [7:0] s;
    s = {2'b10, i[6:1]};
    return {1'b1, {1'b1, i[6:0]} ^ 8'h5C, 1'b0, s ^ 8'h33, s[0], ~s, 1'b1, s ^ 8'hA6};
  endfunction : lutc
  task give_verdict();
    if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk)
    if (rd_d) chk("rdata", 36'({rok, rdat}), 36'(q.pop_front()));
  initial
  begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    #1000000;
    n_fail++;
    give_verdict();
  end
  initial
  begin
    {rst_n, conv, wr, rd, stp, addr, wd, temp} = '0;
    acc = 4'h8;
    aut = 4'hF;
    void'($urandom(4746));
    for (int i = 4; i < 7; i++) tv[i] = int'($urandom_range(36352)) - 10240;
    repeat (20) @(posedge clk);
    #2 rst_n = 1;
    for (int a = 8'h81; a < 8'h8A; a++) rdx(8'(a), 9'h100);
    for (int a = 0; a < 16; a++)
    begin
      acc = 4'(a);
      rdx(8'h88, {a[3] | (a[2] & (a[1] | a[0])), 8'h00});
    end
    p = 8'h00;
    for (int a = 0; a < 16; a++)
    begin
      acc = 4'(a);
      v = 9'($urandom);
      wrx(8'h88, v[7:0]);
      if (a[3] | (a[2] & a[1])) p = v[7:0];
      acc = 4'h8;
      rdx(8'h88, {1'b1, p});
    end
    for (int s = 0; s < 8; s++)
    begin
      v = 9'($urandom);
      wrx(8'h88, {v[7:3], 3'(s)});
      @(negedge clk);
      chk("cycles", 36'(cyc), 36'(ns[s] / 25));
      repeat (2) @(negedge clk iff tick);
      n = 0;
      do
      begin
        @(negedge clk);
        n++;
      end while (!tick);
      chk("tick_gap", 36'(n), 36'(ns[s] / 25));
    end
    for (int i = 0; i < 7; i++)
    begin
      cv(tv[i]);
      idx = idx_of(tv[i]);
      eo = lutc(idx);
      rdx(8'h81, {1'b1, idx});
      chk("lut_addr", 36'(la), 36'({1'b1, idx[6:0], 2'b10, idx[6:1]}));
      chk("codes", outc, eo);
      rdx(8'h82, {8'h80, eo.mod_code[8]});
      rdx(8'h83, {1'b1, eo.mod_code[7:0]});
    end
    wrx(8'h81, 8'hA3);
    aut.auto_index_enable = 0;
    acc = 4'h5;
    wrx(8'h81, 8'hA3);
    acc = 4'h6;
    rdx(8'h81, {1'b1, idx});
    wrx(8'h81, 8'hA3);
    rdx(8'h81, 9'h1A3);
    chk("codes_held", outc, eo);
    cv(0);
    eo = lutc(8'hA3);
    chk("codes_new", outc, eo);
    aut = 4'h0;
    for (int k = 0; k < 3; k++)
    begin
      v = 9'($urandom);
      sh = (k == 0) ? 27 : 18 - 9 * k;
      wrx(8'(8'h82 + 2 * k), {v[7:1], v[8]});
      wrx(8'(8'h83 + 2 * k), v[7:0]);
      chk("before_stop", outc, eo);
      bstop();
      @(posedge clk);
      #2 eo[sh +: 9] = v;
      chk("after_stop", outc, eo);
      rdx(8'(8'h82 + 2 * k), {8'h80, v[8]});
      rdx(8'(8'h83 + 2 * k), {1'b1, v[7:0]});
    end
    cv(-5000);
    chk("codes_kept", outc, eo);
    aut = 4'hF;
    acc = 4'h8;
    wrx(8'h83, ~eo.mod_code[7:0]);
    bstop();
    rdx(8'h83, {1'b1, eo.mod_code[7:0]});
    give_verdict();
  end
endmodule : temp_indexed_lut_ctrl_regs_tb

// ---- test/tli_lut_model.sv ----
// table data seen by the lut control registers
// assumes combinational data for the address presented
`timescale 1ns/1ps
module tli_lut_model
  import tli_pkg::*;
(
  input  wire tli_lut_addr_type i_addr,
  output tli_codes_type         o_data
);
  assign o_data = {1'b1, i_addr.mod_addr ^ 8'h5C, 1'b0, i_addr.shared_addr ^ 8'h33,
                   i_addr.shared_addr[0], ~i_addr.shared_addr, 1'b1, i_addr.shared_addr ^ 8'hA6};
endmodule : tli_lut_model

// ---- test/tli_regs_asserts.sv ----
// port checks of the lut control registers
// assumes one clock and an active-low async reset
`timescale 1ns/1ps
module tli_regs_asserts
  import tli_pkg::*;
(
  input wire logic               i_mclk,
  input wire logic               i_rst_n,
  input wire logic signed [15:0] i_temp_value,
  input wire logic               i_conv_done,
  input wire tli_access_type     i_access,
  input wire tli_auto_type       i_auto,
  input wire tli_codes_type      i_lut_data,
  input wire logic               i_reg_rd,
  input wire logic               i_bus_stop,
  input wire tli_lut_addr_type   o_lut_addr,
  input wire logic [7:0]         o_reg_rdata,
  input wire logic               o_reg_rd_ok,
  input wire tli_codes_type      o_out_codes,
  input wire logic               o_sample_tick
);
  logic [16:0] t_ofs;
  logic [7:0]  idx_calc;
  logic        rd_perm;
  logic        conv_ix;
  assign t_ofs    = 17'(i_temp_value) + 17'h0_2800;
  assign idx_calc = 8'h80 + 8'(t_ofs[16:9]);
  assign rd_perm  = i_access.top_password_level | (i_access.lower_password_level
                    & (i_access.table_readwrite_permit | i_access.table_readonly_permit));
  assign conv_ix  = i_conv_done & i_auto.auto_index_enable;
  default clocking dc @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  addr_map_a: assert property (o_lut_addr.mod_addr[7] &&
    o_lut_addr.shared_addr == {2'b10, o_lut_addr.mod_addr[6:1]}) else $error("lut address map");
  idx_low_a: assert property (conv_ix && i_temp_value < 16'shD800
    |=> o_lut_addr.mod_addr == 8'h80) else $error("index low clamp");
  idx_high_a: assert property (conv_ix && i_temp_value > 16'sh6600
    |=> o_lut_addr.mod_addr == 8'hC7) else $error("index high clamp");
  idx_calc_a: assert property (conv_ix && !t_ofs[16] && t_ofs <= 17'h0_8E00
    |=> o_lut_addr.mod_addr == $past(idx_calc)) else $error("index formula");
  mod_recall_a: assert property (i_conv_done && i_auto.auto_mod_enable ##2 1'b1
    |=> o_out_codes.mod_code == $past(i_lut_data.mod_code)) else $error("mod recall");
  aux1_recall_a: assert property (i_conv_done && i_auto.auto_aux1_enable ##2 1'b1
    |=> o_out_codes.aux1_code == $past(i_lut_data.aux1_code)) else $error("aux1 recall");
  aux2_recall_a: assert property (i_conv_done && i_auto.auto_aux2_enable ##2 1'b1
    |=> o_out_codes.aux2_code == $past(i_lut_data.aux2_code)) else $error("aux2 recall");
  recall_skip_a: assert property (i_conv_done && !i_auto.auto_mod_enable
    && !i_bus_stop ##1 !i_bus_stop |=> $stable(o_out_codes.mod_code)) else $error("skip recall");
  rd_deny_a: assert property (i_reg_rd && !rd_perm
    |=> !o_reg_rd_ok && o_reg_rdata == 8'h00) else $error("read refused");
  tick_gap_a: assert property (o_sample_tick
    |=> !o_sample_tick [*8]) else $error("tick spacing");
endmodule : tli_regs_asserts

bind tli_regs tli_regs_asserts chk_u (.*);
